/* hw/dpll_cfg_defs.svh */
`ifndef DPLL_CFG_DEFS_SVH
`define DPLL_CFG_DEFS_SVH

// register addresses on the microprocessor port
`define MAIN_DAMP_ADDR      7'h6B
`define AUX_GAIN_ADDR       7'h6C
`define MAIN_GAIN_ADDR      7'h6D

// reset values
`define MAIN_DAMP_RESET     8'h13
`define AUX_GAIN_RESET      8'hC2

// field positions
`define AUTO_EN_BIT         7
`define ANALOG_GAIN_MSB     6
`define ANALOG_GAIN_LSB     4
`define LOW_FIELD_MSB       2
`define LOW_FIELD_LSB       0

// damping codes
`define DAMP_MIN            3'h1
`define DAMP_MAX            3'h5
`define DAMP_DEFAULT        3'h3

`endif

/* hw/dpll_cfg_pkg.sv */
package dpll_cfg_pkg;

  // host port access carrier
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } cpu_req_t;

  // gain selection handed to the loop of a pll
  typedef struct packed {
    logic       auto_en;
    logic       use_low_ref;
    logic [2:0] pd2_gain;
    logic [2:0] damping;
    logic       damping_valid;
  } loop_cfg_t;

  // locking mode seen by a pll
  typedef enum logic [1:0] {
    MODE_ANALOG  = 2'b01,
    MODE_DIGITAL = 2'b10
  } lock_mode_t;

endpackage

/* hw/dpll_loop_config_regs.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dpll_cfg_defs.svh"

// Function
// - main damping register, reset 0x13, bits 7,3 zero
// - bits 6:4 low-ref analog gain, needs auto-gain
// - bits 2:0 damping code, 1 to 5 valid
// - damping defaults to code 3
// - aux gain register, reset 0xC2, three fields
// - aux analog gain ignored when auto disabled
module dpll_loop_config_regs (
  input  wire logic                    sys_clk,
  input  wire logic                    reset_n,
  input  wire dpll_cfg_pkg::cpu_req_t  cpu_req,
  input  wire logic                    main_auto_gain_en,
  input  wire dpll_cfg_pkg::lock_mode_t main_lock_mode,
  input  wire logic                    main_ref_low_rate,
  input  wire dpll_cfg_pkg::lock_mode_t aux_lock_mode,
  output var  logic [7:0]              cpu_rdata,
  output var  logic                    cpu_rvalid,
  output var  dpll_cfg_pkg::loop_cfg_t main_loop_cfg,
  output var  dpll_cfg_pkg::loop_cfg_t aux_loop_cfg
);
  import dpll_cfg_pkg::*;

  // stored images of the two registers and their next values
  logic [7:0] main_pll_damping_cfg_reg;
  logic [7:0] main_pll_damping_cfg_next;
  logic [7:0] aux_pll_phase_gain_cfg_reg;
  logic [7:0] aux_pll_phase_gain_cfg_next;

  // decoded host strobes and the read answer before its flops
  logic       main_wr_hit;
  logic       aux_wr_hit;
  logic       rvalid_next;
  logic [7:0] rdata_next;

  // loop settings before the output flops
  logic       main_low_ref_sel;
  logic       aux_analog_sel;
  loop_cfg_t  main_loop_next;
  loop_cfg_t  aux_loop_next;

  // true when a host strobe points at the given register
  function automatic logic addr_hit(input logic [6:0] addr,
                                    input logic [6:0] target);
    addr_hit = (addr == target);
  endfunction

  // true when a loop reports analog feedback locking
  function automatic logic is_analog(input lock_mode_t mode);
    is_analog = (mode == MODE_ANALOG);
  endfunction

  // damping code is usable only inside 1..5; 0, 6 and 7 are unused codes
  function automatic logic damp_ok(input logic [2:0] code);
    damp_ok = (code >= `DAMP_MIN) && (code <= `DAMP_MAX);
  endfunction

  // upper three-bit gain field of either register
  function automatic logic [2:0] upper_field(input logic [7:0] word);
    upper_field = word[`ANALOG_GAIN_MSB:`ANALOG_GAIN_LSB];
  endfunction

  // lower three-bit field: damping code or digital-mode gain
  function automatic logic [2:0] lower_field(input logic [7:0] word);
    lower_field = word[`LOW_FIELD_MSB:`LOW_FIELD_LSB];
  endfunction

  // main damping image as stored: bits 7 and 3 forced to zero
  function automatic logic [7:0] main_damp_image(input logic [7:0] wdata);
    main_damp_image = {1'h0, upper_field(wdata), 1'h0, lower_field(wdata)};
  endfunction

  // aux gain image as stored: bit 3 forced to zero
  function automatic logic [7:0] aux_gain_image(input logic [7:0] wdata);
    aux_gain_image = {wdata[`AUTO_EN_BIT], upper_field(wdata), 1'h0, lower_field(wdata)};
  endfunction

  // register image for a read address; unmapped addresses read as zero
  function automatic logic [7:0] read_word(input logic [6:0] addr,
                                           input logic [7:0] main_word,
                                           input logic [7:0] aux_word);
    unique case (addr)
      `MAIN_DAMP_ADDR: read_word = main_word;
      `AUX_GAIN_ADDR:  read_word = aux_word;
      default:         read_word = 8'h00;
    endcase
  endfunction

  // write decode; a write to any other address is ignored
  always_comb begin
    main_wr_hit = cpu_req.wr && addr_hit(cpu_req.addr, `MAIN_DAMP_ADDR);
    aux_wr_hit  = cpu_req.wr && addr_hit(cpu_req.addr, `AUX_GAIN_ADDR);
  end

  // next value of the main damping register
  always_comb begin
    main_pll_damping_cfg_next = main_pll_damping_cfg_reg;
    if (main_wr_hit) begin
      main_pll_damping_cfg_next = main_damp_image(cpu_req.wdata);
    end
  end

  // next value of the aux gain register
  always_comb begin
    aux_pll_phase_gain_cfg_next = aux_pll_phase_gain_cfg_reg;
    if (aux_wr_hit) begin
      aux_pll_phase_gain_cfg_next = aux_gain_image(cpu_req.wdata);
    end
  end

  // main damping register; holds its reset image until written
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      main_pll_damping_cfg_reg <= `MAIN_DAMP_RESET;
    end else begin
      main_pll_damping_cfg_reg <= main_pll_damping_cfg_next;
    end
  end

  // aux gain register; auto-gain selection is on after reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      aux_pll_phase_gain_cfg_reg <= `AUX_GAIN_RESET;
    end else begin
      aux_pll_phase_gain_cfg_reg <= aux_pll_phase_gain_cfg_next;
    end
  end

  // read answer; a read in the cycle of a write returns the old value
  always_comb begin
    rvalid_next = cpu_req.rd;
    rdata_next  = cpu_rdata;
    if (cpu_req.rd) begin
      rdata_next = read_word(cpu_req.addr, main_pll_damping_cfg_reg,
                             aux_pll_phase_gain_cfg_reg);
    end
  end

  // read strobe flop; the answer is flagged for one cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_rvalid <= 1'h0;
    end else begin
      cpu_rvalid <= rvalid_next;
    end
  end

  // read data flop; holds until the next read
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_rdata <= 8'h00;
    end else begin
      cpu_rdata <= rdata_next;
    end
  end

  // low-ref gain only with auto-gain, analog feedback and a slow reference
  always_comb begin
    main_low_ref_sel = main_auto_gain_en
                       && is_analog(main_lock_mode)
                       && main_ref_low_rate;
  end

  // main loop settings before the flop; gain field zero when not selected
  always_comb begin
    main_loop_next               = '0;
    main_loop_next.auto_en       = main_auto_gain_en;
    main_loop_next.use_low_ref   = main_low_ref_sel;
    main_loop_next.damping       = lower_field(main_pll_damping_cfg_reg);
    main_loop_next.damping_valid = damp_ok(lower_field(main_pll_damping_cfg_reg));
    if (main_low_ref_sel) begin
      main_loop_next.pd2_gain = upper_field(main_pll_damping_cfg_reg);
    end
  end

  // main loop output flop
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      main_loop_cfg <= '0;
    end else begin
      main_loop_cfg <= main_loop_next;
    end
  end

  // aux analog field only while auto-gain is on and the loop locks analog
  always_comb begin
    aux_analog_sel = aux_pll_phase_gain_cfg_reg[`AUTO_EN_BIT]
                     && is_analog(aux_lock_mode);
  end

  // aux loop settings; this loop carries no damping or low-ref field
  always_comb begin
    aux_loop_next         = '0;
    aux_loop_next.auto_en = aux_pll_phase_gain_cfg_reg[`AUTO_EN_BIT];
    if (aux_analog_sel) begin
      aux_loop_next.pd2_gain = upper_field(aux_pll_phase_gain_cfg_reg);
    end else begin
      aux_loop_next.pd2_gain = lower_field(aux_pll_phase_gain_cfg_reg);
    end
  end

  // aux loop output flop
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      aux_loop_cfg <= '0;
    end else begin
      aux_loop_cfg <= aux_loop_next;
    end
  end

  // the loops read these settings every cycle; a host write reaches
  // them two edges later: one edge into the register, one into the
  // output flop, so a loop never sees a half-written register
  // the main auto-gain enable lives in a register outside this bank
  // and arrives here as a level on the same clock

endmodule
`default_nettype wire

/* sim/cfg_chk_sva.sv */
`timescale 1ns/10ps
`default_nettype none
// watches the host port and loop outputs of the config bank
module cfg_chk import dpll_cfg_pkg::*; (
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire logic       main_auto_gain_en,
  input wire logic       main_ref_low_rate,
  input wire logic       cpu_rvalid,
  input wire cpu_req_t   cpu_req,
  input wire lock_mode_t main_lock_mode,
  input wire lock_mode_t aux_lock_mode,
  input wire logic [7:0] cpu_rdata,
  input wire loop_cfg_t  main_loop_cfg,
  input wire loop_cfg_t  aux_loop_cfg
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_read_answer: assert property (cpu_req.rd |=> cpu_rvalid) else $error("no answer");
  a_rvalid_cause: assert property (cpu_rvalid |-> $past(cpu_req.rd)) else $error("stray");
  a_main_spare: assert property (cpu_rvalid && $past(cpu_req.addr) == 7'h6B
    |-> (cpu_rdata & 8'h88) == 8'h00) else $error("spare bits");
  a_aux_spare: assert property (cpu_rvalid && $past(cpu_req.addr) == 7'h6C
    |-> !cpu_rdata[3]) else $error("spare bit");
  a_unmapped_zero: assert property (cpu_rvalid && !($past(cpu_req.addr) inside {7'h6B, 7'h6C})
    |-> cpu_rdata == 8'h00) else $error("unmapped");
  a_damp_valid: assert property (main_loop_cfg.damping_valid
    == (main_loop_cfg.damping inside {[1:5]})) else $error("damping");
  a_main_gain: assert property (main_loop_cfg.pd2_gain != 3'h0
    |-> $past(main_auto_gain_en && main_ref_low_rate && main_lock_mode == MODE_ANALOG))
    else $error("gain");
  a_aux_unused: assert property (!aux_loop_cfg.use_low_ref && !aux_loop_cfg.damping_valid)
    else $error("aux");
  c_read: cover property (cpu_rvalid);
  c_main_gain: cover property (main_loop_cfg.pd2_gain != 3'h0);
  c_aux_auto: cover property (aux_loop_cfg.auto_en);
endmodule
`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import dpll_cfg_pkg::*;
  logic       sys_clk = 0, reset_n = 0, m_auto = 0, low = 0, rvalid;
  cpu_req_t   req = '0;
  lock_mode_t m_mode = MODE_ANALOG, a_mode = MODE_ANALOG;
  logic [7:0] rdata;
  loop_cfg_t  m_cfg, a_cfg;
  int         n_mismatch = 0, num_checks = 0;
  always #25 sys_clk = ~sys_clk;
  dpll_loop_config_regs uut (.sys_clk(sys_clk), .reset_n(reset_n), .cpu_req(req),
    .main_auto_gain_en(m_auto), .main_lock_mode(m_mode), .main_ref_low_rate(low),
    .aux_lock_mode(a_mode), .cpu_rdata(rdata), .cpu_rvalid(rvalid),
    .main_loop_cfg(m_cfg), .aux_loop_cfg(a_cfg));
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // host write and read strobes, driven at falling edges
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge sys_clk) req = '{1'h1, 1'h0, a, d};
    @(negedge sys_clk) req.wr = 1'h0;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(negedge sys_clk) req = '{1'h0, 1'h1, a, 8'h00};
    @(negedge sys_clk) req.rd = 1'h0;
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, e);
  endtask
  task automatic report_and_stop;
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (5) @(negedge sys_clk);
    reset_n = 1'b1;
    rd(7'h6B, 8'h13);
    chk({5'h00, m_cfg.damping}, 8'h03);
    rd(7'h6C, 8'hC2);
    wr(7'h6B, 8'hFF);
    rd(7'h6B, 8'h77);
    wr(7'h6C, 8'hFF);
    rd(7'h6C, 8'hF7);
    wr(7'h6D, 8'hAA);
    rd(7'h6D, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(7'h6B, 8'(i));
      chk({7'h00, m_cfg.damping_valid}, {7'h00, i inside {[1:5]}});
    end
    m_auto = 1'b1;
    low = 1'b1;
    wr(7'h6B, 8'h53);
    chk({5'h00, m_cfg.pd2_gain}, 8'h05);
    chk({6'h00, m_cfg.auto_en, m_cfg.use_low_ref}, 8'h03);
    m_mode = MODE_DIGITAL;
    wr(7'h6B, 8'h53);
    chk({5'h00, m_cfg.pd2_gain}, 8'h00);
    m_mode = MODE_ANALOG;
    m_auto = 1'h0;
    wr(7'h6B, 8'h53);
    chk({5'h00, m_cfg.pd2_gain}, 8'h00);
    chk({6'h00, m_cfg.auto_en, m_cfg.use_low_ref}, 8'h00);
    wr(7'h6C, 8'hB6);
    chk({5'h00, a_cfg.pd2_gain}, 8'h03);
    chk({7'h00, a_cfg.auto_en}, 8'h01);
    chk({3'h0, a_cfg.use_low_ref, a_cfg.damping, a_cfg.damping_valid}, 8'h00);
    a_mode = MODE_DIGITAL;
    wr(7'h6C, 8'hB6);
    chk({5'h00, a_cfg.pd2_gain}, 8'h06);
    a_mode = MODE_ANALOG;
    wr(7'h6C, 8'h36);
    chk({5'h00, a_cfg.pd2_gain}, 8'h06);
    chk({7'h00, a_cfg.auto_en}, 8'h00);
    // mid-run reset brings both registers back to their defaults
    reset_n = 1'h0;
    @(negedge sys_clk);
    chk({7'h00, rvalid}, 8'h00);
    chk({5'h00, m_cfg.damping}, 8'h00);
    @(negedge sys_clk) reset_n = 1'h1;
    rd(7'h6B, 8'h13);
    chk({5'h00, m_cfg.damping}, 8'h03);
    rd(7'h6C, 8'hC2);
    report_and_stop;
  end
  // watchdog well past the expected run
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop;
  end
endmodule
bind dpll_loop_config_regs cfg_chk chk (
  .sys_clk(sys_clk),
  .reset_n(reset_n),
  .main_auto_gain_en(main_auto_gain_en),
  .main_ref_low_rate(main_ref_low_rate),
  .cpu_rvalid(cpu_rvalid),
  .cpu_req(cpu_req),
  .main_lock_mode(main_lock_mode),
  .aux_lock_mode(aux_lock_mode),
  .cpu_rdata(cpu_rdata),
  .main_loop_cfg(main_loop_cfg),
  .aux_loop_cfg(aux_loop_cfg)
);
`default_nettype wire
